/* logic/rtbse_core.sv */
/*
 * register-change, address-to-index-base, branch group and first skip tests of a
 * 24-bit processor, executed one instruction at a time under apb control.
 * assumes software loads instruction, effective address and memory word, then writes go;
 * memory stores land in the memory-word register for software to write back.
 */
// Added by the designer: the APB slave port and the register addresses.
// Behaviour
// - function bits 16 and 17 merge B and A into the destination index
// - bits 18, 19 merge index and A into B; bit 20 clears B bytes
// - bits 21, 22 merge index and B into A; bit 23 clears A bytes
// - byte-control bits 9, 10, 11 select groups; only selected bits change
// - destination index cleared in selected bytes first; source indexes untouched
// - index and A exchange swaps selected bytes at once, others kept
// - address-to-index-base copies instruction bits 9-23 into the index; needs bit 0
// - unconditional branch loads the counter with the effective address
// - index increment added to base; branch unless base leaves the address range
// - increment branch: no indexing, two cycles branching, three falling through
// - branch-clear-interrupt clears highest priority set and recognized channel
// - when indirect, final word bits 3-8 are ored into the flags
// - mark place stores counter and flags, zeroes bits 0-2, continues at address+1
// - argument mark stores counter+1, indirect bit, flags; clears flags
// - return increments word, loads low 15 bits, ors bits 3-8 into flags
// - skip-if-equal skips on exact match; two cycles, three with skip
// - skip-if-greater skips when A is signed-greater than memory
// - function bits 12, 13, 14 merge index one, two, three into destination
`timescale 1ns/1ns
module rtbse_core #(
    parameter int NUM_CHANNELS = 8,
    parameter logic [5:0] OPC_BRANCH_CLEAR = 6'o11,
    parameter logic [5:0] OPC_MARK_ARG = 6'o12,
    parameter logic [5:0] OPC_SKIP_EQ = 6'o50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy
);
    import rtbse_pkg::*;

    initial begin
        if (NUM_CHANNELS < 1 || NUM_CHANNELS > 24) begin
            $error("channel count out of range");
        end
        if (OPC_BRANCH_CLEAR == OPC_MARK_ARG || OPC_SKIP_EQ == OPC_BRANCH_CLEAR
                || OPC_SKIP_EQ == OPC_MARK_ARG) begin
            $error("opcodes must differ");
        end
    end

    typedef struct packed {
        rtbse_state_type state;
        logic [1:0] cnt;
        logic [23:0] instr;
        logic [14:0] eaddr;
        logic [23:0] memw;
        logic [23:0] a;
        logic [23:0] b;
        logic [2:0][23:0] x;
        logic [14:0] p;
        logic [5:0] flags;
        logic [NUM_CHANNELS-1:0] int_act;
        logic [NUM_CHANNELS-1:0] int_rec;
        logic illegal;
        logic mem_wr;
        logic taken;
        logic [31:0] rdata;
    } rtbse_regs_type;

    rtbse_regs_type r_q;
    rtbse_regs_type r_d;

    // decoded instruction fields
    logic [5:0] op;
    logic [1:0] tag;
    logic ind;
    logic [14:0] fn;
    logic [23:0] sel_mask;
    logic [2:0][23:0] xsrc;
    logic [23:0] xmerge;
    logic [23:0] xdest;
    logic [23:0] adj_word;
    logic signed [16:0] ibr_sum;
    logic [8:0] ibr_inc;
    logic ibr_stop;
    logic [1:0] cycles;
    logic legal;
    logic acc_setup;
    logic wr_ok;
    logic mapped;

    assign op = r_q.instr[OP_HI:OP_LO];
    assign tag = r_q.instr[TAG_HI:TAG_LO];
    assign ind = r_q.instr[IND_BIT];
    assign fn = r_q.instr[ADR_HI:0];
    assign sel_mask = (fn[BC_G1] ? MASK_G1 : WORD_RESET)
        | (fn[BC_G2] ? MASK_G2 : WORD_RESET)
        | (fn[BC_G3] ? MASK_G3 : WORD_RESET);

    // one source term per index register, all taken from the old values
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_xsrc
            assign xsrc[gi] = fn[FN_IDX1 - gi] ? r_q.x[gi] : WORD_RESET;
        end
    endgenerate
    assign xmerge = xsrc[0] | xsrc[1] | xsrc[2];
    // tag zero is not a register-change destination; index one stands in harmlessly
    assign xdest = (tag == 2'd0) ? r_q.x[0] : r_q.x[tag - 2'd1];

    assign adj_word = r_q.memw + 24'h000001;
    assign ibr_inc = xdest[INC_HI:INC_LO];
    assign ibr_sum = $signed({2'b00, xdest[ADR_HI:0]}) + $signed({{8{ibr_inc[8]}}, ibr_inc});
    // no branch once the base crosses either end of the address range
    assign ibr_stop = (ibr_inc[8] && ibr_sum[16])
        || (!ibr_inc[8] && ibr_inc != 9'h000 && !ibr_sum[16] && ibr_sum[15]);

    // cycle count and legality of the loaded instruction
    always_comb begin
        legal = 1'b1;
        cycles = CYC_ONE;
        if (op == OPC_REG_CHANGE) begin
            legal = ind || (tag != 2'd0);
        end else if (op == OPC_JUMP || op == OPC_BRANCH_CLEAR) begin
            cycles = CYC_ONE;
        end else if (op == OPC_IBR) begin
            legal = tag != 2'd0;
            cycles = ibr_stop ? CYC_THREE : CYC_TWO;
        end else if (op == OPC_MARK_PLACE || op == OPC_MARK_ARG || op == OPC_RETURN) begin
            cycles = CYC_THREE;
        end else if (op == OPC_SKIP_EQ) begin
            cycles = (r_q.a == r_q.memw) ? CYC_THREE : CYC_TWO;
        end else if (op == OPC_SKIP_GT) begin
            cycles = ($signed(r_q.a) > $signed(r_q.memw)) ? CYC_THREE : CYC_TWO;
        end else begin
            legal = 1'b0;
        end
    end

    assign acc_setup = psel && !penable;
    assign wr_ok = psel && penable && pwrite && r_q.state == ST_IDLE;
    always_comb begin
        unique case (paddr)
            OFS_CTRL, OFS_INSTR, OFS_EADDR, OFS_MEMW, OFS_ACC_A, OFS_ACC_B, OFS_INDEX_ONE,
            OFS_INDEX_TWO, OFS_INDEX_THREE, OFS_PC, OFS_FLAGS, OFS_INT_ACT, OFS_INT_REC,
            OFS_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    // writes while executing are refused so the sources stay stable
    assign pslverr = psel && penable && (!mapped || (pwrite && r_q.state == ST_EXEC));
    assign prdata = r_q.rdata;
    assign busy = r_q.state == ST_EXEC;

    always_comb begin
        logic [23:0] a_base;
        logic [23:0] b_base;
        logic found;
        a_base = WORD_RESET;
        b_base = WORD_RESET;
        found = 1'b0;
        r_d = r_q;

        // read data captured in the setup phase
        if (acc_setup) begin
            r_d.rdata = 32'h00000000;
            unique case (paddr)
                OFS_INSTR: r_d.rdata = {8'h00, r_q.instr};
                OFS_EADDR: r_d.rdata = {17'h00000, r_q.eaddr};
                OFS_MEMW: r_d.rdata = {8'h00, r_q.memw};
                OFS_ACC_A: r_d.rdata = {8'h00, r_q.a};
                OFS_ACC_B: r_d.rdata = {8'h00, r_q.b};
                OFS_INDEX_ONE: r_d.rdata = {8'h00, r_q.x[0]};
                OFS_INDEX_TWO: r_d.rdata = {8'h00, r_q.x[1]};
                OFS_INDEX_THREE: r_d.rdata = {8'h00, r_q.x[2]};
                OFS_PC: r_d.rdata = {17'h00000, r_q.p};
                OFS_FLAGS: r_d.rdata = {26'h0000000, r_q.flags};
                OFS_INT_ACT: r_d.rdata[NUM_CHANNELS-1:0] = r_q.int_act;
                OFS_INT_REC: r_d.rdata[NUM_CHANNELS-1:0] = r_q.int_rec;
                OFS_STATUS: begin
                    r_d.rdata[ST_BUSY] = r_q.state == ST_EXEC;
                    r_d.rdata[ST_ILLEGAL] = r_q.illegal;
                    r_d.rdata[ST_MEM_WR] = r_q.mem_wr;
                    r_d.rdata[ST_TAKEN] = r_q.taken;
                end
                default: r_d.rdata = 32'h00000000;
            endcase
        end

        if (wr_ok) begin
            unique case (paddr)
                OFS_CTRL: begin
                    if (pwdata[CTRL_GO_BIT]) begin
                        r_d.state = ST_EXEC;
                        r_d.cnt = cycles;
                        r_d.illegal = 1'b0;
                        r_d.mem_wr = 1'b0;
                        r_d.taken = 1'b0;
                    end
                end
                OFS_INSTR: r_d.instr = pwdata[23:0];
                OFS_EADDR: r_d.eaddr = pwdata[14:0];
                OFS_MEMW: r_d.memw = pwdata[23:0];
                OFS_ACC_A: r_d.a = pwdata[23:0];
                OFS_ACC_B: r_d.b = pwdata[23:0];
                OFS_INDEX_ONE: r_d.x[0] = pwdata[23:0];
                OFS_INDEX_TWO: r_d.x[1] = pwdata[23:0];
                OFS_INDEX_THREE: r_d.x[2] = pwdata[23:0];
                OFS_PC: r_d.p = pwdata[14:0];
                OFS_FLAGS: r_d.flags = pwdata[5:0];
                OFS_INT_ACT: r_d.int_act = pwdata[NUM_CHANNELS-1:0];
                OFS_INT_REC: r_d.int_rec = pwdata[NUM_CHANNELS-1:0];
                default: r_d.state = r_q.state;
            endcase
        end

        // results commit on the last cycle of the instruction
        if (r_q.state == ST_EXEC) begin
            r_d.cnt = r_q.cnt - 2'd1;
            if (r_q.cnt == CYC_ONE) begin
                r_d.state = ST_IDLE;
                r_d.p = r_q.p + PC_STEP;
                if (!legal) begin
                    r_d.illegal = 1'b1;
                    r_d.p = r_q.p;
                end else if (op == OPC_REG_CHANGE && ind) begin
                    // tag zero names no index register, so nothing is loaded
                    if (tag != 2'd0) begin
                        r_d.x[tag - 2'd1] = (xdest & ~MASK_BASE)
                            | (r_q.instr & MASK_BASE);
                    end
                end else if (op == OPC_REG_CHANGE) begin
                    // all terms below read r_q, so exchanges swap cleanly
                    r_d.x[tag - 2'd1] = (xdest & ~sel_mask) | (sel_mask & (xmerge
                        | (fn[FN_B_TO_X] ? r_q.b : WORD_RESET)
                        | (fn[FN_A_TO_X] ? r_q.a : WORD_RESET)));
                    b_base = fn[FN_CLR_B] ? (r_q.b & ~sel_mask) : r_q.b;
                    r_d.b = b_base | (sel_mask & ((fn[FN_X_TO_B] ? xdest : WORD_RESET)
                        | (fn[FN_A_TO_B] ? r_q.a : WORD_RESET)));
                    a_base = fn[FN_CLR_A] ? (r_q.a & ~sel_mask) : r_q.a;
                    r_d.a = a_base | (sel_mask & ((fn[FN_X_TO_A] ? xdest : WORD_RESET)
                        | (fn[FN_B_TO_A] ? r_q.b : WORD_RESET)));
                end else if (op == OPC_JUMP) begin
                    r_d.p = r_q.eaddr;
                    r_d.taken = 1'b1;
                end else if (op == OPC_IBR) begin
                    r_d.x[tag - 2'd1] = {xdest[INC_HI:INC_LO], ibr_sum[ADR_HI:0]};
                    if (!ibr_stop) begin
                        r_d.p = r_q.eaddr;
                        r_d.taken = 1'b1;
                    end
                end else if (op == OPC_BRANCH_CLEAR) begin
                    r_d.p = r_q.eaddr;
                    r_d.taken = 1'b1;
                    // lowest channel number is the highest priority
                    for (int i = 0; i < NUM_CHANNELS; i++) begin
                        if (!found && r_q.int_act[i] && r_q.int_rec[i]) begin
                            r_d.int_act[i] = 1'b0;
                            found = 1'b1;
                        end
                    end
                    if (ind) begin
                        r_d.flags = r_q.flags | r_q.memw[FLG_HI:FLG_LO];
                    end
                end else if (op == OPC_MARK_PLACE) begin
                    r_d.memw = {3'b000, r_q.flags, r_q.p};
                    r_d.mem_wr = 1'b1;
                    r_d.p = r_q.eaddr + PC_STEP;
                    r_d.taken = 1'b1;
                end else if (op == OPC_MARK_ARG) begin
                    r_d.memw = {1'b1, 2'b00, r_q.flags, r_q.p + PC_STEP};
                    r_d.mem_wr = 1'b1;
                    r_d.flags = FLAGS_RESET;
                    r_d.p = r_q.eaddr + PC_STEP;
                    r_d.taken = 1'b1;
                end else if (op == OPC_RETURN) begin
                    r_d.p = adj_word[ADR_HI:0];
                    r_d.flags = r_q.flags | adj_word[FLG_HI:FLG_LO];
                    r_d.taken = 1'b1;
                end else if (op == OPC_SKIP_EQ) begin
                    if (r_q.a == r_q.memw) begin
                        r_d.p = r_q.p + PC_SKIP;
                        r_d.taken = 1'b1;
                    end
                end else if (op == OPC_SKIP_GT) begin
                    if ($signed(r_q.a) > $signed(r_q.memw)) begin
                        r_d.p = r_q.p + PC_SKIP;
                        r_d.taken = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
endmodule : rtbse_core

/* logic/rtbse_pkg.sv */
/*
 * constants for the register-change, branch and skip execution block:
 * apb offsets, instruction fields, function and byte-control bits, opcodes, cycle counts.
 * assumes 24-bit words; vector bit 23 is the most significant (leftmost) word bit.
 */
package rtbse_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_INSTR = 8'h04;
    localparam logic [7:0] OFS_EADDR = 8'h08;
    localparam logic [7:0] OFS_MEMW = 8'h0c;
    localparam logic [7:0] OFS_ACC_A = 8'h10;
    localparam logic [7:0] OFS_ACC_B = 8'h14;
    localparam logic [7:0] OFS_INDEX_ONE = 8'h18;
    localparam logic [7:0] OFS_INDEX_TWO = 8'h1c;
    localparam logic [7:0] OFS_INDEX_THREE = 8'h20;
    localparam logic [7:0] OFS_PC = 8'h24;
    localparam logic [7:0] OFS_FLAGS = 8'h28;
    localparam logic [7:0] OFS_INT_ACT = 8'h2c;
    localparam logic [7:0] OFS_INT_REC = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;
    localparam int CTRL_GO_BIT = 0;
    // status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_ILLEGAL = 1;
    localparam int ST_MEM_WR = 2;
    localparam int ST_TAKEN = 3;
    // instruction word fields
    localparam int IND_BIT = 23;
    localparam int TAG_HI = 22;
    localparam int TAG_LO = 21;
    localparam int OP_HI = 20;
    localparam int OP_LO = 15;
    localparam int ADR_HI = 14;
    localparam int FLG_HI = 20;
    localparam int FLG_LO = 15;
    // function bits of the address field
    localparam int FN_IDX1 = 11;
    localparam int FN_B_TO_X = 7;
    localparam int FN_A_TO_X = 6;
    localparam int FN_X_TO_B = 5;
    localparam int FN_A_TO_B = 4;
    localparam int FN_CLR_B = 3;
    localparam int FN_X_TO_A = 2;
    localparam int FN_B_TO_A = 1;
    localparam int FN_CLR_A = 0;
    // byte-control bits and the register groups they select
    localparam int BC_G1 = 14;
    localparam int BC_G2 = 13;
    localparam int BC_G3 = 12;
    localparam logic [23:0] MASK_G1 = 24'o77700000;
    localparam logic [23:0] MASK_G2 = 24'o00077000;
    localparam logic [23:0] MASK_G3 = 24'o00000777;
    localparam logic [23:0] MASK_BASE = 24'o00077777;
    // index register: increment in the upper nine bits, base in the low fifteen
    localparam int INC_HI = 23;
    localparam int INC_LO = 15;
    // opcodes
    localparam logic [5:0] OPC_REG_CHANGE = 6'o40;
    localparam logic [5:0] OPC_JUMP = 6'o01;
    localparam logic [5:0] OPC_IBR = 6'o57;
    localparam logic [5:0] OPC_MARK_PLACE = 6'o03;
    localparam logic [5:0] OPC_RETURN = 6'o41;
    localparam logic [5:0] OPC_SKIP_GT = 6'o46;
    // cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [14:0] PC_STEP = 15'h0001;
    localparam logic [14:0] PC_SKIP = 15'h0002;
    localparam logic [23:0] WORD_RESET = 24'h000000;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    typedef enum logic {ST_IDLE, ST_EXEC} rtbse_state_type;
endpackage : rtbse_pkg

/* bench/rtbse_core_asserts.sv */
/* checker for rtbse_core: how long busy stands after each kind of go.
   assumes only the top ports are visible; bound to the core at the foot. */
`timescale 1ns/1ns
module rtbse_core_asserts
    import rtbse_pkg::*;
#(
    parameter int NUM_CHANNELS = 8,
    parameter logic [5:0] OPC_BRANCH_CLEAR = 6'o11,
    parameter logic [5:0] OPC_MARK_ARG = 6'o12,
    parameter logic [5:0] OPC_SKIP_EQ = 6'o50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy
);
    logic [23:0] instr_q;
    logic go;
    logic ok;
    logic [5:0] opc;
    // copy kept only for writes the core accepts, so refused writes do not skew it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q <= 24'h000000;
        end else if (psel && penable && pwrite && !busy && paddr == OFS_INSTR) begin
            instr_q <= pwdata[23:0];
        end
    end
    assign go = psel && penable && pwrite && !busy && paddr == OFS_CTRL && pwdata[CTRL_GO_BIT];
    assign opc = instr_q[OP_HI:OP_LO];
    assign ok = go && instr_q[TAG_HI:TAG_LO] != 2'h0;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    reg_change_time_a: assert property (ok && opc == OPC_REG_CHANGE
        && !instr_q[IND_BIT] |=> busy ##1 !busy) else $error("register change not one cycle");
    index_base_time_a: assert property (ok && opc == OPC_REG_CHANGE && instr_q[IND_BIT]
        |=> busy ##1 !busy) else $error("index base load not one cycle");
    branch_time_a: assert property (go && opc == OPC_JUMP |=> busy ##1 !busy)
        else $error("branch not one cycle");
    clear_int_time_a: assert property (go && opc == OPC_BRANCH_CLEAR
        |=> busy ##1 $fell(busy)) else $error("branch clear not one cycle");
    incr_branch_time_a: assert property (ok && opc == OPC_IBR
        |=> busy[*2] ##[1:2] $fell(busy)) else $error("increment branch not two or three cycles");
    mark_place_time_a: assert property (go && opc == OPC_MARK_PLACE
        |=> busy[*3] ##1 !busy) else $error("mark place not three cycles");
    mark_arg_time_a: assert property (go && opc == OPC_MARK_ARG |=> busy[*3] ##1 !busy)
        else $error("mark argument not three cycles");
    return_time_a: assert property (go && opc == OPC_RETURN |=> busy[*3] ##1 !busy)
        else $error("return not three cycles");
    skip_eq_time_a: assert property (go && opc == OPC_SKIP_EQ
        |=> busy[*2] ##[1:2] $fell(busy)) else $error("skip equal not two or three cycles");
    skip_gt_time_a: assert property (go && opc == OPC_SKIP_GT
        |=> busy[*2] ##[1:2] $fell(busy)) else $error("skip greater not two or three cycles");
endmodule : rtbse_core_asserts

bind rtbse_core rtbse_core_asserts #(.NUM_CHANNELS(NUM_CHANNELS),
    .OPC_BRANCH_CLEAR(OPC_BRANCH_CLEAR), .OPC_MARK_ARG(OPC_MARK_ARG),
    .OPC_SKIP_EQ(OPC_SKIP_EQ)) rtbse_core_asserts_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

/* bench/rtbse_core_test.sv */
/* self-checking bench for rtbse_core: apb master, register model, read and busy monitor.
   assumes zero-wait apb and busy high for each execution cycle. */
`timescale 1ns/1ns
module rtbse_core_test;
    import rtbse_pkg::*;
    localparam logic [5:0] OPC_BC = 6'o11;
    localparam logic [5:0] OPC_MA = 6'o12;
    localparam logic [5:0] OPC_SE = 6'o50;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, busy;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int cyc_q[$];
    int mismatches = 0, n_tests = 0, seed = 67266, cnt = 0;
    logic [23:0] a = 0, b = 0, w, m, xo, an, bn, in;
    logic [23:0] x[1:3] = '{0, 0, 0};
    logic [14:0] p = 0;
    logic [5:0] f = 0;
    logic [1:0] tg;
    always #20 pclk = ~pclk;
    rtbse_core #(.OPC_BRANCH_CLEAR(OPC_BC), .OPC_MARK_ARG(OPC_MA), .OPC_SKIP_EQ(OPC_SE))
        rtbse_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy));
    // reads are compared in their access cycle, run lengths when busy drops
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            n_tests++;
            e = exp_q.pop_front();
            if ({pslverr, prdata} !== e) begin
                mismatches++;
                $display("unexpected at %0t: read %h gave %h, want %h", $time, paddr, prdata, e);
            end
        end
        if (psel && penable && pready && pwrite && pslverr !== 1'b0) begin
            mismatches++;
            $display("unexpected at %0t: write %h refused", $time, paddr);
        end
        if (busy === 1'b1)
            cnt++;
        else if (cnt > 0) begin
            n_tests++;
            if (cnt != cyc_q.pop_front()) begin
                mismatches++;
                $display("unexpected at %0t: busy lasted %0d cycles", $time, cnt);
            end
            cnt = 0;
        end
    end
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task automatic apb(input logic wr_en, input logic [7:0] ad, input logic [31:0] d,
        input logic [32:0] ex);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= ad;
        pwdata <= d;
        if (!wr_en)
            exp_q.push_back(ex);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            results();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb
    task automatic wr(input logic [7:0] ad, input logic [23:0] d);
        apb(1'b1, ad, {8'h00, d}, 33'h0);
    endtask : wr
    task automatic ck(input logic [7:0] ad, input logic [23:0] d);
        apb(1'b0, ad, 32'h0, {9'h000, d});
    endtask : ck
    task automatic setall();
        wr(OFS_ACC_A, a);
        wr(OFS_ACC_B, b);
        wr(OFS_INDEX_ONE, x[1]);
        wr(OFS_INDEX_TWO, x[2]);
        wr(OFS_INDEX_THREE, x[3]);
        wr(OFS_FLAGS, {18'h0, f});
    endtask : setall
    task automatic ckall(input string s);
        ck(OFS_ACC_A, a);
        ck(OFS_ACC_B, b);
        ck(OFS_INDEX_ONE, x[1]);
        ck(OFS_INDEX_TWO, x[2]);
        ck(OFS_INDEX_THREE, x[3]);
        ck(OFS_PC, {9'h0, p});
        ck(OFS_FLAGS, {18'h0, f});
        $display("end of %s", s);
    endtask : ckall
    task automatic run(input logic [23:0] ins, input logic [14:0] ea, input logic [23:0] mw,
        input int c);
        int n = 0;
        wr(OFS_INSTR, ins);
        wr(OFS_EADDR, {9'h0, ea});
        wr(OFS_MEMW, mw);
        wr(OFS_PC, {9'h0, p});
        cyc_q.push_back(c);
        wr(OFS_CTRL, 24'h000001);
        while (busy !== 1'b0 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (busy !== 1'b0) begin
            mismatches++;
            results();
        end
    endtask : run
    function automatic logic [23:0] rnd();
        logic [31:0] t;
        t = $random(seed);
        return t[23:0];
    endfunction : rnd
    function automatic logic [23:0] sel(input logic c, input logic [23:0] v);
        return c ? v : 24'h000000;
    endfunction : sel
    task automatic ibr(input logic [8:0] inc, input logic [14:0] base, input logic tk);
        x[2] = {inc, base};
        setall();
        run({3'b010, OPC_IBR, 15'h0}, 15'o1234, 24'h0, tk ? 2 : 3);
        x[2] = {inc, base + {{6{inc[8]}}, inc}};
        p = tk ? 15'o1234 : p + PC_STEP;
        ckall("increment branch");
    endtask : ibr
    task automatic sk(input logic [5:0] op, input logic [23:0] av, input logic [23:0] mv,
        input logic s);
        a = av;
        setall();
        run({3'b000, op, 15'h0}, 15'h0, mv, s ? 3 : 2);
        p = s ? p + PC_SKIP : p + PC_STEP;
        ckall("skip");
    endtask : sk
    initial begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        results();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ckall("reset values");
        apb(1'b0, 8'h3c, 32'h0, {1'b1, 32'h0});
        run(24'h000000, 15'h0, 24'h0, 1);
        ck(OFS_STATUS, 24'h000002);
        run({3'b000, OPC_REG_CHANGE, 15'o70000}, 15'h0, 24'h0, 1);
        ck(OFS_STATUS, 24'h000002);
        ckall("refused instructions");
        for (int i = 0; i < 9; i++) begin
            a = rnd();
            b = rnd();
            x[1] = rnd();
            x[2] = rnd();
            x[3] = rnd();
            w = rnd();
            tg = 2'(i % 3 + 1);
            // a byte-control field of zero would leave every register unchanged, so force one group
            in = {1'b0, tg, OPC_REG_CHANGE, (w[14:12] == 3'b0) ? 3'b001 : w[14:12],
                w[11:0]};
            setall();
            run(in, 15'h0, 24'h0, 1);
            m = sel(in[BC_G1], MASK_G1) | sel(in[BC_G2], MASK_G2) | sel(in[BC_G3], MASK_G3);
            xo = x[tg];
            an = (in[FN_CLR_A] ? a & ~m : a)
                | m & (sel(in[FN_X_TO_A], xo) | sel(in[FN_B_TO_A], b));
            bn = (in[FN_CLR_B] ? b & ~m : b)
                | m & (sel(in[FN_X_TO_B], xo) | sel(in[FN_A_TO_B], a));
            x[tg] = xo & ~m | m & (sel(in[FN_IDX1], x[1]) | sel(in[FN_IDX1 - 1], x[2])
                | sel(in[FN_IDX1 - 2], x[3]) | sel(in[FN_B_TO_X], b) | sel(in[FN_A_TO_X], a));
            a = an;
            b = bn;
            p = p + PC_STEP;
            ckall("register change");
            w = rnd();
            run({1'b1, tg, OPC_REG_CHANGE, w[14:0]}, 15'h0, 24'h0, 1);
            x[tg] = {x[tg][INC_HI:INC_LO], w[14:0]};
            p = p + PC_STEP;
            ckall("index base load");
        end
        w = rnd();
        run({3'b000, OPC_JUMP, 15'h0}, w[14:0], 24'h0, 1);
        p = w[14:0];
        ckall("branch");
        ibr(9'h001, 15'h7fff, 1'b0);
        ibr(9'h1ff, 15'h0000, 1'b0);
        ibr(9'h001, 15'h7ffe, 1'b1);
        ibr(9'h1ff, 15'h0005, 1'b1);
        wr(OFS_INT_ACT, 24'h000006);
        wr(OFS_INT_REC, 24'h00000c);
        f = 6'o21;
        setall();
        run({3'b100, OPC_BC, 15'h0}, 15'o4120, 24'o05304120, 1);
        f = 6'o73;
        p = 15'o4120;
        ck(OFS_INT_ACT, 24'h000002);
        ckall("indirect branch clear");
        run({3'b000, OPC_BC, 15'h0}, 15'o300, 24'o07700000, 1);
        p = 15'o300;
        ckall("direct branch clear");
        f = 6'o46;
        p = 15'o1517;
        setall();
        run({3'b000, OPC_MARK_PLACE, 15'h0}, 15'o2500, 24'o03207621, 3);
        p = 15'o2501;
        ck(OFS_MEMW, 24'o04601517);
        ck(OFS_STATUS, 24'h00000c);
        ckall("mark place");
        f = 6'o27;
        p = 15'o2000;
        setall();
        run({3'b000, OPC_MA, 15'h0}, 15'o4030, 24'h0, 3);
        f = 6'o00;
        p = 15'o4031;
        ck(OFS_MEMW, 24'o42702001);
        ckall("mark argument");
        f = 6'o23;
        setall();
        run({3'b000, OPC_RETURN, 15'h0}, 15'o14200, 24'o06500400, 3);
        f = 6'o67;
        p = 15'o401;
        ckall("return");
        w = rnd();
        sk(OPC_SE, w, w, 1'b1);
        sk(OPC_SE, w, w ^ 24'h000100, 1'b0);
        sk(OPC_SKIP_GT, 24'h000001, 24'hffffff, 1'b1);
        sk(OPC_SKIP_GT, 24'hffffff, 24'h000001, 1'b0);
        sk(OPC_SKIP_GT, 24'h000005, 24'h000005, 1'b0);
        sk(OPC_SKIP_GT, 24'h7fffff, 24'h800000, 1'b1);
        results();
    end
endmodule : rtbse_core_test
